// ---- rtl/lwa_pkg.sv ----
/*
 * Constants shared by the limit window alert configuration block: pointer
 * codes, field positions, values after reset and conversion timing.
 * Assumes a 10 MHz core clock and a 3-bit register pointer.
 */

package lwa_pkg;

    // Register pointer codes.
    localparam logic [2:0] PTR_STATUS = 3'h1;
    localparam logic [2:0] PTR_CONFIG = 3'h2;
    localparam logic [2:0] PTR_LOWER  = 3'h3;
    localparam logic [2:0] PTR_UPPER  = 3'h4;
    localparam logic [2:0] PTR_MARGIN = 3'h5;

    // Configuration field positions.
    localparam int CFG_INTERVAL_HI = 7;
    localparam int CFG_INTERVAL_LO = 5;
    localparam int CFG_HOLD_BIT    = 4;
    localparam int CFG_FLAG_EN_BIT = 3;
    localparam int CFG_PIN_EN_BIT  = 2;
    localparam int CFG_RSVD_BIT    = 1;
    localparam int CFG_POL_BIT     = 0;

    // Threshold word layout and violation status bits.
    localparam int LIM_HI         = 11;
    localparam int LIM_LO         = 4;
    localparam int STAT_OVER_BIT  = 1;
    localparam int STAT_UNDER_BIT = 0;

    // Values after reset.
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam logic [15:0] LOWER_RESET  = 16'h0000;
    localparam logic [15:0] UPPER_RESET  = 16'h0FFF;
    localparam logic [15:0] MARGIN_RESET = 16'h0000;

    // Timing: the single conversion period is a least time, rounded up.
    localparam int CLK_PERIOD_NS                   = 100;
    localparam int SINGLE_CONVERSION_PERIOD_NS     = 1000;
    localparam int SINGLE_CONVERSION_PERIOD_CYC    =
        (SINGLE_CONVERSION_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TIMER_W             = 24;
    localparam logic [3:0]  INTERVAL_SHIFT_BASE = 4'h4;

    typedef enum logic [1:0] {
        LWA_IDLE  = 2'b00,
        LWA_KICK  = 2'b01,
        LWA_SPACE = 2'b11
    } lwa_sched_t;

endpackage

// ---- rtl/lwa_core.sv ----
/*
 * Limit window alert configuration: configuration, threshold and margin
 * registers, violation flags, automatic conversion scheduling and the
 * alert pin. Registers are reached from the serial engine's clock domain
 * over a toggle handshake; the converter sits on the core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module lwa_core
    import lwa_pkg::*;
#(
    parameter int SINGLE_CONVERSION_PERIOD = SINGLE_CONVERSION_PERIOD_CYC
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        lnk_clk,
    input  wire logic [2:0]  lnk_ptr,
    input  wire logic        lnk_wr_stb,
    input  wire logic        lnk_rd_stb,
    input  wire logic [15:0] lnk_wdata,
    output logic      [15:0] lnk_rdata,
    output logic             lnk_rd_valid,
    output logic             lnk_busy,
    input  wire logic        conv_done,
    input  wire logic [7:0]  conv_result,
    output logic             conv_start,
    output logic             auto_mode,
    output logic             result_flag_d15,
    output logic             alert_pin_o,
    output logic             alert_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: request capture and answer collection.
    logic        lrst_ff1_reg, lrst_reg;
    logic        l_req_tgl_reg, l_req_tgl_next;
    logic        l_is_wr_reg, l_is_wr_next;
    logic [2:0]  l_ptr_reg, l_ptr_next;
    logic [15:0] l_wdata_reg, l_wdata_next;
    logic        l_busy_reg, l_busy_next;
    logic        l_ack_ff1_reg, l_ack_ff2_reg;
    logic        l_ack_seen_reg, l_ack_seen_next;
    logic [15:0] l_rdata_reg, l_rdata_next;
    logic        l_rd_valid_reg, l_rd_valid_next;
    logic        c_ack_tgl_reg, c_ack_tgl_next;
    logic [15:0] c_rd_hold_reg, c_rd_hold_next;
    // The link side keeps pointer and data still while busy, so the core
    // may read them once the request toggle has passed its synchroniser.
    always_comb begin
        l_req_tgl_next  = l_req_tgl_reg;
        l_is_wr_next    = l_is_wr_reg;
        l_ptr_next      = l_ptr_reg;
        l_wdata_next    = l_wdata_reg;
        l_busy_next     = l_busy_reg;
        l_ack_seen_next = l_ack_seen_reg;
        l_rdata_next    = l_rdata_reg;
        l_rd_valid_next = 1'b0;
        if (l_busy_reg) begin
            if (l_ack_ff2_reg != l_ack_seen_reg) begin
                l_ack_seen_next = l_ack_ff2_reg;
                l_busy_next     = 1'b0;
                if (!l_is_wr_reg) begin
                    l_rdata_next    = c_rd_hold_reg;
                    l_rd_valid_next = 1'b1;
                end
            end
        end else if (lnk_wr_stb || lnk_rd_stb) begin
            l_is_wr_next   = lnk_wr_stb;
            l_ptr_next     = lnk_ptr;
            l_wdata_next   = lnk_wdata;
            l_req_tgl_next = ~l_req_tgl_reg;
            l_busy_next    = 1'b1;
        end
    end
    always_ff @(posedge lnk_clk) begin
        lrst_ff1_reg  <= sys_rst;
        lrst_reg      <= lrst_ff1_reg;
        l_ack_ff1_reg <= c_ack_tgl_reg;
        l_ack_ff2_reg <= l_ack_ff1_reg;
        if (lrst_reg) begin
            l_req_tgl_reg  <= 1'b0;
            l_is_wr_reg    <= 1'b0;
            l_ptr_reg      <= 3'h0;
            l_wdata_reg    <= 16'h0000;
            l_busy_reg     <= 1'b0;
            l_ack_seen_reg <= 1'b0;
            l_rdata_reg    <= 16'h0000;
            l_rd_valid_reg <= 1'b0;
        end else begin
            l_req_tgl_reg  <= l_req_tgl_next;
            l_is_wr_reg    <= l_is_wr_next;
            l_ptr_reg      <= l_ptr_next;
            l_wdata_reg    <= l_wdata_next;
            l_busy_reg     <= l_busy_next;
            l_ack_seen_reg <= l_ack_seen_next;
            l_rdata_reg    <= l_rdata_next;
            l_rd_valid_reg <= l_rd_valid_next;
        end
    end
    assign lnk_rdata    = l_rdata_reg;
    assign lnk_rd_valid = l_rd_valid_reg;
    assign lnk_busy     = l_busy_reg;
    ////////////////////////////////////////////////////////////////////////
    // Core domain: request execution and register file.
    logic       c_req_ff1_reg, c_req_ff2_reg;
    logic       c_req_seen_reg, c_req_seen_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] lower_reg, lower_next;
    logic [7:0] upper_reg, upper_next;
    logic [7:0] margin_reg, margin_next;
    logic       over_reg, over_next;
    logic       under_reg, under_next;
    logic       req_pend, host_clr_over, host_clr_under;
    logic [15:0] read_word;
    logic [2:0] interval;
    assign req_pend = c_req_ff2_reg != c_req_seen_reg;
    assign interval = cfg_reg[CFG_INTERVAL_HI:CFG_INTERVAL_LO];
    always_comb begin
        unique case (l_ptr_reg)
            PTR_STATUS: read_word = {14'h0000, over_reg, under_reg};
            PTR_CONFIG: read_word = {8'h00, cfg_reg};
            PTR_LOWER:  read_word = {4'h0, lower_reg, 4'h0};
            PTR_UPPER:  read_word = {4'h0, upper_reg, 4'h0};
            PTR_MARGIN: read_word = {4'h0, margin_reg, 4'h0};
            default:    read_word = 16'h0000;
        endcase
    end
    always_comb begin
        c_req_seen_next = c_req_seen_reg;
        c_ack_tgl_next  = c_ack_tgl_reg;
        c_rd_hold_next  = c_rd_hold_reg;
        cfg_next        = cfg_reg;
        lower_next      = lower_reg;
        upper_next      = upper_reg;
        margin_next     = margin_reg;
        host_clr_over   = 1'b0;
        host_clr_under  = 1'b0;
        if (req_pend) begin
            c_req_seen_next = c_req_ff2_reg;
            c_ack_tgl_next  = ~c_ack_tgl_reg;
            if (l_is_wr_reg) begin
                unique case (l_ptr_reg)
                    PTR_STATUS: begin
                        host_clr_over  = l_wdata_reg[STAT_OVER_BIT];
                        host_clr_under = l_wdata_reg[STAT_UNDER_BIT];
                    end
                    PTR_CONFIG: begin
                        cfg_next               = l_wdata_reg[7:0];
                        cfg_next[CFG_RSVD_BIT] = 1'b0;
                    end
                    PTR_LOWER:  lower_next  = l_wdata_reg[LIM_HI:LIM_LO];
                    PTR_UPPER:  upper_next  = l_wdata_reg[LIM_HI:LIM_LO];
                    PTR_MARGIN: margin_next = l_wdata_reg[LIM_HI:LIM_LO];
                    default: ;
                endcase
            end else begin
                c_rd_hold_next = read_word;
            end
        end
    end
    always_ff @(posedge clk) begin
        c_req_ff1_reg <= l_req_tgl_reg;
        c_req_ff2_reg <= c_req_ff1_reg;
        if (sys_rst) begin
            c_req_seen_reg <= 1'b0;
            c_ack_tgl_reg  <= 1'b0;
            c_rd_hold_reg  <= 16'h0000;
            cfg_reg        <= CFG_RESET;
            lower_reg      <= LOWER_RESET[LIM_HI:LIM_LO];
            upper_reg      <= UPPER_RESET[LIM_HI:LIM_LO];
            margin_reg     <= MARGIN_RESET[LIM_HI:LIM_LO];
        end else begin
            c_req_seen_reg <= c_req_seen_next;
            c_ack_tgl_reg  <= c_ack_tgl_next;
            c_rd_hold_reg  <= c_rd_hold_next;
            cfg_reg        <= cfg_next;
            lower_reg      <= lower_next;
            upper_reg      <= upper_next;
            margin_reg     <= margin_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Automatic conversion scheduler.
    lwa_sched_t           state_reg, state_next;
    logic [TIMER_W-1:0]   timer_reg, timer_next;
    logic [TIMER_W-1:0]   spacing;
    // Spacing is the single period shifted by four plus the interval code.
    assign spacing = TIMER_W'(SINGLE_CONVERSION_PERIOD)
                     << ({1'b0, interval} + INTERVAL_SHIFT_BASE);
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        unique case (state_reg)
            LWA_IDLE: if (interval != 3'h0) state_next = LWA_KICK;
            LWA_KICK: begin
                timer_next = spacing - TIMER_W'(2);
                state_next = (interval == 3'h0) ? LWA_IDLE : LWA_SPACE;
            end
            LWA_SPACE: begin
                if (interval == 3'h0) begin
                    state_next = LWA_IDLE;
                end else if (timer_reg == '0) begin
                    state_next = LWA_KICK;
                end else begin
                    timer_next = timer_reg - TIMER_W'(1);
                end
            end
            default: state_next = LWA_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= LWA_IDLE;
            timer_reg <= '0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end
    assign conv_start = state_reg == LWA_KICK;
    assign auto_mode  = state_reg != LWA_IDLE;
    ////////////////////////////////////////////////////////////////////////
    // Violation flags, result flag bit and alert pin.
    logic [8:0] res9, upper9, lower9, margin9;
    logic       over_hit, under_hit, over_back, under_back, hold;
    logic       d15_reg, d15_next, pin_reg, pin_next, oe_reg, oe_next;
    assign res9       = {1'b0, conv_result};
    assign upper9     = {1'b0, upper_reg};
    assign lower9     = {1'b0, lower_reg};
    assign margin9    = {1'b0, margin_reg};
    assign hold       = cfg_reg[CFG_HOLD_BIT];
    assign over_hit   = conv_done && (res9 > upper9);
    assign under_hit  = conv_done && (res9 < lower9);
    // Back inside by more than the margin; nine bits keep sums honest.
    assign over_back  = conv_done && !hold && (res9 + margin9 < upper9);
    assign under_back = conv_done && !hold && (res9 > lower9 + margin9);
    // A new violation wins over a clear in the same cycle.
    always_comb begin
        over_next  = over_hit || (over_reg && !host_clr_over && !over_back);
        under_next = under_hit || (under_reg && !host_clr_under && !under_back);
        d15_next   = cfg_reg[CFG_FLAG_EN_BIT] && (over_reg || under_reg);
        oe_next    = cfg_reg[CFG_PIN_EN_BIT];
        pin_next   = cfg_reg[CFG_POL_BIT] ? (over_reg || under_reg)
                                          : !(over_reg || under_reg);
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            over_reg  <= 1'b0;
            under_reg <= 1'b0;
            d15_reg   <= 1'b0;
            pin_reg   <= 1'b1;
            oe_reg    <= 1'b0;
        end else begin
            over_reg  <= over_next;
            under_reg <= under_next;
            d15_reg   <= d15_next;
            pin_reg   <= pin_next;
            oe_reg    <= oe_next;
        end
    end
    assign result_flag_d15 = d15_reg;
    assign alert_pin_o     = pin_reg;
    assign alert_pin_oe    = oe_reg;
    ////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [TIMER_W-1:0] gap_reg;
    logic               steady_reg;
    always_ff @(posedge clk) begin
        if (sys_rst || conv_start) begin
            gap_reg <= TIMER_W'(1);
        end else begin
            gap_reg <= gap_reg + TIMER_W'(1);
        end
        if (sys_rst || interval == 3'h0 || interval != cfg_next[7:5]) begin
            steady_reg <= 1'b0;
        end else if (conv_start) begin
            steady_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_reset_config: assert property ($fell(sys_rst) |-> cfg_reg == CFG_RESET)
        else $error("config not zero after reset");
    chk_idle_no_start: assert property (
        interval == 3'h0 && $past(interval) == 3'h0 |-> !conv_start)
        else $error("conversion started with interval zero");
    chk_auto_begin: assert property (
        state_reg == LWA_IDLE && interval != 3'h0 |=> conv_start)
        else $error("automatic conversion did not begin");
    chk_conv_spacing: assert property (
        conv_start && steady_reg && $past(!conv_start) |-> gap_reg == spacing)
        else $error("conversion spacing wrong");
    chk_over_set: assert property (over_hit |=> over_reg)
        else $error("over-range flag not raised");
    chk_under_set: assert property (under_hit |=> under_reg)
        else $error("under-range flag not raised");
    chk_hold_keeps: assert property (
        hold && over_reg && !host_clr_over |=> over_reg)
        else $error("held flag cleared without host write");
    chk_self_clear: assert property (
        over_reg && over_back && !over_hit && !host_clr_over |=> !over_reg)
        else $error("flag failed to self-clear");
    chk_host_clear: assert property (
        host_clr_under && !under_hit |=> !under_reg)
        else $error("under flag not cleared by host");
    chk_d15_gate: assert property (
        !cfg_reg[CFG_FLAG_EN_BIT] |=> !result_flag_d15)
        else $error("result flag shown while gated off");
    chk_pin_release: assert property (
        !cfg_reg[CFG_PIN_EN_BIT] |=> !alert_pin_oe)
        else $error("alert pin driven while disabled");
    chk_pin_level: assert property (
        ##1 alert_pin_oe |-> alert_pin_o ==
            ($past(cfg_reg[CFG_POL_BIT]) ~^ $past(over_reg || under_reg)))
        else $error("alert pin level wrong");
    chk_reserved_zero: assert property (
        c_rd_hold_reg[15:12] == 4'h0 && cfg_reg[CFG_RSVD_BIT] == 1'b0)
        else $error("reserved bits not zero");
endmodule
`default_nettype wire

// ---- tb/lwa_link_master.sv ----
/*
 * Model of the serial engine that reaches the register port over the
 * link clock: one request at a time, held until the port answers.
 * Assumes lnk_clk runs free and the testbench calls xfer hierarchically.
 */
`timescale 1ns/1ns
`default_nettype none

module lwa_link_master (
    input  wire logic        lnk_clk,
    input  wire logic        lnk_busy,
    output logic      [2:0]  lnk_ptr,
    output logic             lnk_wr_stb,
    output logic             lnk_rd_stb,
    output logic      [15:0] lnk_wdata
);
    int hang_cnt = 0;

    initial begin
        lnk_ptr    = 3'h0;
        lnk_wr_stb = 1'b0;
        lnk_rd_stb = 1'b0;
        lnk_wdata  = 16'h0000;
    end

    // Pointer and data are inverted once released so that a design that
    // samples them late cannot pass by reading a stale value.
    task automatic xfer(input logic is_wr, input logic [2:0] p, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge lnk_clk);
        lnk_ptr    = p;
        lnk_wdata  = d;
        lnk_wr_stb = is_wr;
        lnk_rd_stb = !is_wr;
        @(negedge lnk_clk);
        lnk_wr_stb = 1'b0;
        lnk_rd_stb = 1'b0;
        while (lnk_busy !== 1'b0 && n < 20) begin
            @(negedge lnk_clk);
            n++;
        end
        if (n >= 20) hang_cnt++;
        lnk_ptr   = ~p;
        lnk_wdata = ~d;
    endtask
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
/*
 * Self-checking testbench for the limit window alert block: register
 * defaults, threshold flags, alert pin, result flag and auto spacing.
 * Assumes lwa_pkg is compiled first; the converter is played here.
 */
`timescale 1ns/1ns
`default_nettype none

module tb
    import lwa_pkg::*;
;
    logic        clk = 1'b0;
    logic        lnk_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        conv_done = 1'b0;
    logic [7:0]  conv_result = 8'h00;
    logic [2:0]  lnk_ptr;
    logic        lnk_wr_stb;
    logic        lnk_rd_stb;
    logic [15:0] lnk_wdata;
    logic [15:0] lnk_rdata;
    logic        lnk_rd_valid;
    logic        lnk_busy;
    logic        conv_start;
    logic        auto_mode;
    logic        result_flag_d15;
    logic        alert_pin_o;
    logic        alert_pin_oe;
    logic [15:0] exp_q[$];
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          n;
    logic [15:0] v;

    always #50 clk = ~clk;
    initial #7 forever #16 lnk_clk = ~lnk_clk;

    lwa_core #(.SINGLE_CONVERSION_PERIOD(1)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .lnk_clk(lnk_clk), .lnk_ptr(lnk_ptr),
        .lnk_wr_stb(lnk_wr_stb), .lnk_rd_stb(lnk_rd_stb), .lnk_wdata(lnk_wdata),
        .lnk_rdata(lnk_rdata), .lnk_rd_valid(lnk_rd_valid), .lnk_busy(lnk_busy),
        .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
        .auto_mode(auto_mode), .result_flag_d15(result_flag_d15),
        .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe)
    );

    lwa_link_master u_link (
        .lnk_clk(lnk_clk), .lnk_busy(lnk_busy), .lnk_ptr(lnk_ptr),
        .lnk_wr_stb(lnk_wr_stb), .lnk_rd_stb(lnk_rd_stb), .lnk_wdata(lnk_wdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic conclude();
        error_cnt += u_link.hang_cnt + exp_q.size();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] p, input logic [15:0] d);
        u_link.xfer(1'b1, p, d);
    endtask

    task automatic rd(input logic [2:0] p, input logic [15:0] e);
        exp_q.push_back(e);
        u_link.xfer(1'b0, p, 16'h0000);
    endtask

    // The result byte between pulses is noise, so only the pulse edge may carry it.
    task automatic conv(input logic [7:0] r);
        @(negedge clk);
        conv_done   = 1'b1;
        conv_result = r;
        @(negedge clk);
        conv_done   = 1'b0;
        conv_result = 8'($urandom);
        repeat (4) @(negedge clk);
    endtask

    task automatic pins(input logic d15, input logic oe, input logic o);
        check({15'h0000, result_flag_d15}, {15'h0000, d15}, "result flag");
        check({15'h0000, alert_pin_oe}, {15'h0000, oe}, "pin enable");
        if (oe) check({15'h0000, alert_pin_o}, {15'h0000, o}, "pin level");
    endtask

    task automatic wait_start(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (conv_start !== 1'b1 && cnt < 3000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge lnk_clk) begin
        if (lnk_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) check(lnk_rdata, 16'hFFFF, "unexpected read answer");
            else check(lnk_rdata, exp_q.pop_front(), "read word");
        end
    end

    initial begin
        #4_000_000;
        error_cnt++;
        conclude();
    end

    initial begin
        void'($urandom(63));
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge lnk_clk);
        pins(1'b0, 1'b0, 1'b1);
        rd(PTR_CONFIG, 16'h0000);
        rd(PTR_LOWER, 16'h0000);
        rd(PTR_UPPER, 16'h0FF0);
        rd(PTR_MARGIN, 16'h0000);
        rd(PTR_STATUS, 16'h0000);
        rd(3'h0, 16'h0000);
        rd(3'h7, 16'h0000);
        for (int p = 3; p < 6; p++) begin
            v = {4'h0, 8'($urandom), 4'h0};
            wr(3'(p), v);
            rd(3'(p), v);
        end
        v = {8'h00, 8'($urandom) & 8'h1D};
        wr(PTR_CONFIG, v);
        rd(PTR_CONFIG, v);
        // Window 20h..80h with margin 10h; no hold, gate on, pin active high.
        wr(PTR_UPPER, 16'h0800);
        wr(PTR_LOWER, 16'h0200);
        wr(PTR_MARGIN, 16'h0100);
        wr(PTR_CONFIG, 16'h000D);
        conv(8'h80);
        conv(8'h20);
        rd(PTR_STATUS, 16'h0000);
        pins(1'b0, 1'b1, 1'b0);
        conv(8'h90);
        rd(PTR_STATUS, 16'h0002);
        pins(1'b1, 1'b1, 1'b1);
        conv(8'h75);
        rd(PTR_STATUS, 16'h0002);
        conv(8'h6F);
        rd(PTR_STATUS, 16'h0000);
        pins(1'b0, 1'b1, 1'b0);
        // Hold on, pin active low.
        wr(PTR_CONFIG, 16'h001C);
        conv(8'h10);
        rd(PTR_STATUS, 16'h0001);
        pins(1'b1, 1'b1, 1'b0);
        conv(8'h50);
        rd(PTR_STATUS, 16'h0001);
        wr(PTR_STATUS, 16'h0001);
        rd(PTR_STATUS, 16'h0000);
        repeat (3) @(negedge clk);
        pins(1'b0, 1'b1, 1'b1);
        // Gate and pin off: flag still recorded but hidden.
        wr(PTR_CONFIG, 16'h0000);
        conv(8'h90);
        rd(PTR_STATUS, 16'h0002);
        pins(1'b0, 1'b0, 1'b0);
        wr(PTR_STATUS, 16'h0002);
        rd(PTR_STATUS, 16'h0000);
        for (int c = 1; c < 8; c++) begin
            wr(PTR_CONFIG, {8'h00, 3'(c), 5'h00});
            wait_start(n);
            check({15'h0000, auto_mode}, 16'h0001, "auto on");
            wait_start(n);
            check(16'(n), 16'(1 << (4 + c)), "spacing");
            wr(PTR_CONFIG, 16'h0000);
            n = 0;
            while (auto_mode !== 1'b0 && n < 2100) begin
                @(negedge clk);
                n++;
            end
            wait_start(n);
            check(16'(n), 16'd3000, "no start when off");
        end
        conclude();
    end
endmodule

`default_nettype wire
